//--- hdl/usc_map.svh
// Register offsets, field positions and reset values of the slave control bank.
// Assumes an 8-bit register pointer loaded over the host port.
`ifndef USC_MAP_SVH
`define USC_MAP_SVH

// Register offsets
`define USC_OFS_CTRL  8'h05
`define USC_OFS_IEN   8'h06
`define USC_OFS_ADDR  8'h07
`define USC_OFS_ISTAT 8'h0D
`define USC_OFS_CBUF  8'h0E
`define USC_OFS_ROLE  8'h0F
`define USC_OFS_FRML  8'h15
`define USC_OFS_FRMH  8'h16
`define USC_OFS_DMAL  8'h35
`define USC_OFS_DMAH  8'h36

// Field positions
`define USC_BIT_DMA_STATUS 7
`define USC_BIT_STANDBY    6
`define USC_BIT_SPEED      5
`define USC_EVT_WIDTH      7

// Reset values
`define USC_RST_CTRL 8'h00
`define USC_RST_IEN  7'h00
`define USC_RST_ADDR 8'h00
`define USC_RST_ROLE 8'h00
`define USC_RST_DMA  16'h0000

`endif

//--- hdl/usc_pkg.sv
// Types shared by the slave control bank and its helpers.
// Assumes nothing of its surroundings.
package usc_pkg;

  // Main control register layout, bit 7 first
  typedef struct packed {
    logic reserved;
    logic transceiverStandby;
    logic speedSelect;
    logic lineForceHi;
    logic lineForceLo;
    logic dmaRead;
    logic dmaEnable;
    logic usbEnable;
  } usc_ctrl_s;

  // Forced bus line states
  typedef enum logic [1:0] {
    USC_LINE_NORMAL = 2'b00,
    USC_LINE_SE0    = 2'b01,
    USC_LINE_K      = 2'b10,
    USC_LINE_J      = 2'b11
  } usc_line_e;

  // Event pulses from the packet engine, status bits 6..0
  typedef struct packed {
    logic       usbReset;
    logic       sofReceived;
    logic       dmaDone;
    logic [3:0] epDone;
  } usc_evt_s;

  // Decoded token from the packet engine
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } usc_token_s;

endpackage : usc_pkg

//--- hdl/usc_irq_status.sv
// Sticky event status with write-one-to-clear and enable gating.
// Assumes single-cycle event and clear pulses from the register bank.
`timescale 1ns/1ps
module usc_irq_status #(
  parameter int W = 7
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] setEvt,
  input  wire logic [W-1:0] clrWr,
  input  wire logic [W-1:0] enable,
  output logic      [W-1:0] status,
  output logic              irqOut
);

  // Event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else if (ce) begin
      status <= (status & ~clrWr) | setEvt;
    end
  end

  // Request follows pending and enabled bits, one cycle late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqOut <= 1'b0;
    end else if (ce) begin
      irqOut <= |(status & enable);
    end
  end

endmodule : usc_irq_status

//--- hdl/usc_addr_filter.sv
// Token address filter against the assigned device address.
// Assumes tokens arrive as one-cycle valid pulses.
`timescale 1ns/1ps
module usc_addr_filter
  import usc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire usc_token_s tokenIn,
  input  wire logic [7:0] devAddr,
  input  wire logic       usbEnable,
  output logic            tokenAccept,
  output logic            tokenReject
);

  // Accept only matching tokens while transfers are enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tokenAccept <= 1'b0;
      tokenReject <= 1'b0;
    end else if (ce) begin
      tokenAccept <= tokenIn.valid && usbEnable && (tokenIn.addr == devAddr);
      tokenReject <= tokenIn.valid && !(usbEnable && (tokenIn.addr == devAddr));
    end
  end

endmodule : usc_addr_filter

//--- hdl/usc_slave_ctrl_regs.sv
// Slave-mode USB control and interrupt register bank on the 8-bit host port.
// Assumes host strobes synchronous to clk and event pulses from the packet engine.
// Functional notes
// - Control bit 6 puts transceiver in standby
// - Suspend when standby set and enable clear
// - Control bit 5: zero full, one low speed
// - Line force bits give normal, SE0, K, J
// - Line force bits clear at power-up
// - Control bit 2 sets DMA direction
// - DMA starts on high count write if enabled
// - USB enable resets to zero, gates communication
// - Enables gate request only, never touch status
// - Enable bits: reset, SOF, DMA, endpoints
// - Bit 7 reads DMA transfer in progress
// - Device address resets to 00h
// - Respond only to tokens matching device address
// - Read status; write one clears bit
// - Endpoint completion sets its done status bit
`timescale 1ns/1ps
`include "usc_map.svh"
module usc_slave_ctrl_regs
  import usc_pkg::*;
#(
  parameter int NUM_EP = 4
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        hostCsN,
  input  wire logic        hostRdN,
  input  wire logic        hostWrN,
  input  wire logic        hostA0,
  input  wire logic [7:0]  hostDataIn,
  output logic      [7:0]  hostDataOut,
  output logic             hostDataOeN,
  output logic             interruptRequestOut,
  input  wire usc_evt_s    evtIn,
  input  wire logic [3:0]  currentBufferIn,
  input  wire logic [10:0] frameNumberIn,
  input  wire usc_token_s  tokenIn,
  output logic             tokenAccept,
  output logic             tokenReject,
  output logic             usbEnableOut,
  output logic             xcvrStandby,
  output logic             suspendOut,
  output logic             lowSpeed,
  output logic             lineForceOeN,
  output logic             lineDpOut,
  output logic             lineDmOut,
  output logic             dmaReadDir,
  output logic             dmaStart,
  output logic             dmaActive,
  output logic      [15:0] dmaCount,
  output logic      [7:0]  rolePolarity
);

  // Register bits only cover four endpoints
  generate
    if (NUM_EP < 1 || NUM_EP > 4) begin : g_bad_ep
      $error("NUM_EP must lie between 1 and 4");
    end
  endgenerate

  usc_ctrl_s                    ctrlReg;
  logic [`USC_EVT_WIDTH-1:0]    ienReg;
  logic [7:0]                   addrReg;
  logic [7:0]                   ptrReg;
  logic                         wrNPrev;
  logic                         wrEdge;
  logic                         rdActive;
  logic                         wrCtrl;
  logic                         wrIen;
  logic                         wrDmaHigh;
  logic [`USC_EVT_WIDTH-1:0]    clrVec;
  logic [`USC_EVT_WIDTH-1:0]    evtVec;
  logic [`USC_EVT_WIDTH-1:0]    irqStatus;
  logic [7:0]                   readData;
  usc_line_e                    lineSel;

  // True when a data-phase write targets the given offset
  function automatic logic regHit(input logic [7:0] ptr, input logic [7:0] ofs, input logic edgeOk);
    regHit = edgeOk && (ptr == ofs);
  endfunction : regHit

  // Host strobe edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrNPrev <= 1'b1;
    end else if (ce) begin
      wrNPrev <= hostWrN;
    end
  end

  // Decoded host accesses
  assign wrEdge    = !hostCsN && !hostWrN && wrNPrev;
  assign rdActive  = !hostCsN && !hostRdN;
  assign wrCtrl    = regHit(ptrReg, `USC_OFS_CTRL, wrEdge && hostA0);
  assign wrIen     = regHit(ptrReg, `USC_OFS_IEN, wrEdge && hostA0);
  assign wrDmaHigh = regHit(ptrReg, `USC_OFS_DMAH, wrEdge && hostA0);
  assign clrVec    = regHit(ptrReg, `USC_OFS_ISTAT, wrEdge && hostA0) ? hostDataIn[6:0] : '0;
  assign evtVec    = evtIn;

  // Register pointer, loaded by the address phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptrReg <= 8'h00;
    end else if (ce && wrEdge && !hostA0) begin
      ptrReg <= hostDataIn;
    end
  end

  // Main control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlReg <= `USC_RST_CTRL;
    end else if (ce && wrCtrl) begin
      ctrlReg          <= hostDataIn;
      ctrlReg.reserved <= 1'b0;
    end
  end

  // Interrupt enables, bit 7 is read-only status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ienReg <= `USC_RST_IEN;
    end else if (ce && wrIen) begin
      ienReg <= hostDataIn[6:0];
    end
  end

  // Device address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addrReg <= `USC_RST_ADDR;
    end else if (ce && regHit(ptrReg, `USC_OFS_ADDR, wrEdge && hostA0)) begin
      addrReg <= hostDataIn;
    end
  end

  // Role and polarity byte, kept for the transceiver
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rolePolarity <= `USC_RST_ROLE;
    end else if (ce && regHit(ptrReg, `USC_OFS_ROLE, wrEdge && hostA0)) begin
      rolePolarity <= hostDataIn;
    end
  end

  // DMA count bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dmaCount <= `USC_RST_DMA;
    end else if (ce) begin
      if (regHit(ptrReg, `USC_OFS_DMAL, wrEdge && hostA0)) begin
        dmaCount[7:0] <= hostDataIn;
      end
      if (wrDmaHigh) begin
        dmaCount[15:8] <= hostDataIn;
      end
    end
  end

  // DMA start pulse and busy flag, a start beats a done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dmaStart  <= 1'b0;
      dmaActive <= 1'b0;
    end else if (ce) begin
      dmaStart <= wrDmaHigh && ctrlReg.dmaEnable;
      if (wrDmaHigh && ctrlReg.dmaEnable) begin
        dmaActive <= 1'b1;
      end else if (evtIn.dmaDone) begin
        dmaActive <= 1'b0;
      end
    end
  end

  // Sticky status and request output
  usc_irq_status #(
    .W (`USC_EVT_WIDTH)
  ) u_irq (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .setEvt (evtVec),
    .clrWr  (clrVec),
    .enable (ienReg),
    .status (irqStatus),
    .irqOut (interruptRequestOut)
  );

  // Token address filter
  usc_addr_filter u_filter (
    .clk         (clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .tokenIn     (tokenIn),
    .devAddr     (addrReg),
    .usbEnable   (ctrlReg.usbEnable),
    .tokenAccept (tokenAccept),
    .tokenReject (tokenReject)
  );

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    readData = 8'h00;
    if (!hostA0) begin
      readData = ptrReg;
    end else begin
      unique case (ptrReg)
        `USC_OFS_CTRL:  readData = ctrlReg;
        `USC_OFS_IEN:   readData = {dmaActive, ienReg};
        `USC_OFS_ADDR:  readData = addrReg;
        `USC_OFS_ISTAT: readData = {dmaActive, irqStatus};
        `USC_OFS_CBUF:  readData = {4'h0, currentBufferIn};
        `USC_OFS_ROLE:  readData = rolePolarity;
        `USC_OFS_FRML:  readData = {frameNumberIn[6:0], 1'b0};
        `USC_OFS_FRMH:  readData = {frameNumberIn[10:7], 4'h0};
        `USC_OFS_DMAL:  readData = dmaCount[7:0];
        `USC_OFS_DMAH:  readData = dmaCount[15:8];
        default:        readData = 8'h00;
      endcase
    end
  end

  // Host data driver, enable low while driving
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hostDataOut <= 8'h00;
      hostDataOeN <= 1'b1;
    end else if (ce) begin
      hostDataOut <= readData;
      hostDataOeN <= !rdActive;
    end
  end

  // Transceiver mode outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usbEnableOut <= 1'b0;
      xcvrStandby  <= 1'b0;
      suspendOut   <= 1'b0;
      lowSpeed     <= 1'b0;
      dmaReadDir   <= 1'b0;
    end else if (ce) begin
      usbEnableOut <= ctrlReg.usbEnable;
      xcvrStandby  <= ctrlReg.transceiverStandby;
      suspendOut   <= ctrlReg.transceiverStandby && !ctrlReg.usbEnable;
      lowSpeed     <= ctrlReg.speedSelect;
      dmaReadDir   <= ctrlReg.dmaRead;
    end
  end

  // Forced line state decode
  assign lineSel = usc_line_e'({ctrlReg.lineForceHi, ctrlReg.lineForceLo});

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineForceOeN <= 1'b1;
      lineDpOut    <= 1'b0;
      lineDmOut    <= 1'b0;
    end else if (ce) begin
      unique case (lineSel)
        USC_LINE_NORMAL: begin
          lineForceOeN <= 1'b1;
          lineDpOut    <= 1'b0;
          lineDmOut    <= 1'b0;
        end
        USC_LINE_SE0: begin
          lineForceOeN <= 1'b0;
          lineDpOut    <= 1'b0;
          lineDmOut    <= 1'b0;
        end
        USC_LINE_K: begin
          lineForceOeN <= 1'b0;
          lineDpOut    <= 1'b0;
          lineDmOut    <= 1'b1;
        end
        USC_LINE_J: begin
          lineForceOeN <= 1'b0;
          lineDpOut    <= 1'b1;
          lineDmOut    <= 1'b0;
        end
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_reserved_zero: assert property (ctrlReg.reserved == 1'b0)
    else $error("reserved control bit set");

  chk_standby_follow: assert property (ce |=> xcvrStandby == $past(ctrlReg.transceiverStandby))
    else $error("standby output wrong");

  chk_suspend_entry: assert property (
    ce && wrCtrl ##1 ce |=> suspendOut == ($past(hostDataIn[6], 2) && !$past(hostDataIn[0], 2)))
    else $error("suspend not tied to standby and enable");

  chk_speed_select: assert property (ce |=> lowSpeed == $past(ctrlReg.speedSelect))
    else $error("speed output wrong");

  chk_force_j_state: assert property (
    ce && ctrlReg.lineForceHi && ctrlReg.lineForceLo |=> !lineForceOeN && lineDpOut && !lineDmOut)
    else $error("J state not driven");

  chk_force_k_state: assert property (
    ce && ctrlReg.lineForceHi && !ctrlReg.lineForceLo |=> !lineForceOeN && !lineDpOut && lineDmOut)
    else $error("K state not driven");

  chk_force_normal: assert property (
    ce && !ctrlReg.lineForceHi && !ctrlReg.lineForceLo |=> lineForceOeN)
    else $error("line driven in normal mode");

  chk_dma_direction: assert property (ce && wrCtrl ##1 ce |=> dmaReadDir == $past(hostDataIn[2], 2))
    else $error("DMA direction wrong");

  chk_dma_start: assert property (ce && wrDmaHigh && ctrlReg.dmaEnable |=> dmaStart && dmaActive)
    else $error("DMA did not start");

  chk_dma_no_start: assert property (ce && wrDmaHigh && !ctrlReg.dmaEnable |=> !dmaStart)
    else $error("DMA started while disabled");

  chk_dma_status_read: assert property (
    ce && hostA0 && ptrReg == `USC_OFS_ISTAT |=> hostDataOut[`USC_BIT_DMA_STATUS] == $past(dmaActive))
    else $error("DMA status bit wrong");

  chk_usb_gate: assert property (ce && !ctrlReg.usbEnable |=> !tokenAccept)
    else $error("token accepted while disabled");

  chk_addr_filter: assert property (ce && tokenIn.valid && tokenIn.addr != addrReg |=> !tokenAccept && tokenReject)
    else $error("foreign token accepted");

  chk_irq_gate: assert property (ce |=> interruptRequestOut == |($past(irqStatus) & $past(ienReg)))
    else $error("request not status and enable");

  chk_ien_no_effect: assert property (ce && wrIen && evtVec == '0 |=> irqStatus == $past(irqStatus))
    else $error("enable write changed status");

  chk_event_sets: assert property (ce && evtVec != '0 |=> (irqStatus & $past(evtVec)) == $past(evtVec))
    else $error("event did not set status");

  chk_w1c_clears: assert property (ce && clrVec != '0 && evtVec == '0 |=> (irqStatus & $past(clrVec)) == '0)
    else $error("write one did not clear");

  chk_set_wins: assert property (ce && (evtVec & clrVec) != '0 |=> (irqStatus & $past(evtVec & clrVec)) != '0)
    else $error("clear beat new event");

  chk_addr_reset: assert property ($rose(rst_n) |-> addrReg == `USC_RST_ADDR)
    else $error("address not zero after reset");

  cov_dma_run: cover property (ce && dmaStart ##[1:50] evtIn.dmaDone);
  cov_irq_raise: cover property (ce && evtIn.epDone[0] && ienReg[0] ##2 interruptRequestOut);
  cov_token_ok: cover property (tokenAccept && addrReg != 8'h00);
  cov_force_k: cover property (!lineForceOeN && lineDmOut);

endmodule : usc_slave_ctrl_regs

//--- test/usc_host_model.sv
// Host bus master: loads the register pointer, then writes or reads one register.
// Assumes the slave takes a write on the strobe's falling edge and answers reads one cycle on.
`timescale 1ns/1ps
`include "usc_map.svh"
module usc_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] hostDataOut,
  input  wire logic       hostDataOeN,
  output logic            hostCsN,
  output logic            hostRdN,
  output logic            hostWrN,
  output logic            hostA0,
  output logic [7:0]      hostDataIn
);
  // Idle bus from time zero
  initial begin
    hostCsN    = 1'b1;
    hostRdN    = 1'b1;
    hostWrN    = 1'b1;
    hostA0     = 1'b0;
    hostDataIn = 8'h00;
  end

  // One write strobe; strobe goes high again so the next one is seen
  task automatic strobe(input logic a0, input logic [7:0] d);
    @(posedge clk);
    hostCsN    <= 1'b0;
    hostWrN    <= 1'b0;
    hostA0     <= a0;
    hostDataIn <= d;
    @(posedge clk);
    hostWrN    <= 1'b1;
    hostCsN    <= 1'b1;
    hostDataIn <= ~d;  // Released bus never shows the last value
  endtask : strobe

  task automatic setPtr(input logic [7:0] a);
    strobe(1'b0, a);
  endtask : setPtr

  task automatic wrData(input logic [7:0] d);
    strobe(1'b1, d);
  endtask : wrData

  // Pointer then data; control bit 7 always sent as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == `USC_OFS_CTRL) v[7] = 1'b0;
    setPtr(a);
    wrData(v);
  endtask : wr

  // Pointer then read strobe; data taken one edge after strobe is driven
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic oeN);
    setPtr(a);
    @(posedge clk);
    hostCsN <= 1'b0;
    hostRdN <= 1'b0;
    hostA0  <= 1'b1;
    @(posedge clk);
    #1;
    d   = hostDataOut;
    oeN = hostDataOeN;
    @(posedge clk);
    hostRdN <= 1'b1;
    hostCsN <= 1'b1;
  endtask : rd

  // Low count first, high count always written since it starts the transfer
  task automatic dmaLen(input logic [15:0] cnt);
    wr(`USC_OFS_DMAL, cnt[7:0]);
    wr(`USC_OFS_DMAH, cnt[15:8]);
  endtask : dmaLen

  // Ones clear pending bits, zeros leave them
  task automatic clrStatus(input logic [7:0] m);
    wr(`USC_OFS_ISTAT, m);
  endtask : clrStatus
endmodule : usc_host_model

//--- test/tb_top.sv
// Self-checking bench for the slave control and interrupt register bank.
// Assumes the host model as bus master and the bench as packet engine.
`timescale 1ns/1ps
`include "usc_map.svh"
module tb_top
  import usc_pkg::*;
;
  logic clk, rstN, ce, hostCsN, hostRdN, hostWrN, hostA0, hostDataOeN, irq;
  logic [7:0]  hostDataIn, hostDataOut, rolePolarity;
  logic [3:0]  curBuf;
  logic [10:0] frameNum;
  logic [15:0] dmaCount;
  usc_evt_s    evtIn;
  usc_token_s  tokenIn;
  logic tokenAccept, tokenReject, usbEn, xcvrStandby, suspendOut, lowSpeed;
  logic lineForceOeN, lineDpOut, lineDmOut, dmaReadDir, dmaStart, dmaActive;
  int nMismatch, samplesChecked, cycles, nAccept, nReject, nStart;

  usc_host_model u_host (.clk(clk), .hostDataOut(hostDataOut), .hostDataOeN(hostDataOeN),
    .hostCsN(hostCsN), .hostRdN(hostRdN), .hostWrN(hostWrN), .hostA0(hostA0), .hostDataIn(hostDataIn));

  usc_slave_ctrl_regs #(.NUM_EP(4)) u_dut (.clk(clk), .rst_n(rstN), .ce(ce), .hostCsN(hostCsN),
    .hostRdN(hostRdN), .hostWrN(hostWrN), .hostA0(hostA0), .hostDataIn(hostDataIn),
    .hostDataOut(hostDataOut), .hostDataOeN(hostDataOeN), .interruptRequestOut(irq), .evtIn(evtIn),
    .currentBufferIn(curBuf), .frameNumberIn(frameNum), .tokenIn(tokenIn), .tokenAccept(tokenAccept),
    .tokenReject(tokenReject), .usbEnableOut(usbEn), .xcvrStandby(xcvrStandby), .suspendOut(suspendOut),
    .lowSpeed(lowSpeed), .lineForceOeN(lineForceOeN), .lineDpOut(lineDpOut), .lineDmOut(lineDmOut),
    .dmaReadDir(dmaReadDir), .dmaStart(dmaStart), .dmaActive(dmaActive), .dmaCount(dmaCount),
    .rolePolarity(rolePolarity));

  // Clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // Pulse counters and hang guard
  always @(posedge clk) begin
    cycles++;
    if (tokenAccept === 1'b1) nAccept++;
    if (tokenReject === 1'b1) nReject++;
    if (dmaStart === 1'b1) nStart++;
    if (cycles > 5000) begin
      nMismatch++;
      stop_test();
    end
  end

  task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpVal

  task automatic cmpBit(input logic got, input logic exp);
    cmpVal({15'h0000, got}, {15'h0000, exp});
  endtask : cmpBit

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       oeN;
    u_host.rd(a, d, oeN);
    cmpVal({8'h00, d}, {8'h00, exp});
    cmpBit(oeN, 1'b0);
  endtask : rdChk

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic pulse(input logic [6:0] e);
    @(posedge clk);
    evtIn <= e;
    @(posedge clk);
    evtIn <= '0;
  endtask : pulse

  task automatic token(input logic [7:0] a);
    @(posedge clk);
    tokenIn <= {1'b1, a};
    @(posedge clk);
    tokenIn <= '0;
  endtask : token

  task automatic t_reset;
    #1;
    cmpBit(lineForceOeN, 1'b1);
    cmpBit(usbEn, 1'b0);
    rdChk(`USC_OFS_CTRL, 8'h00);
    rdChk(`USC_OFS_ADDR, 8'h00);
    rdChk(`USC_OFS_IEN, 8'h00);
  endtask : t_reset

  // Every line-force code with standby off and on; speed and suspend each seen in both states
  task automatic t_ctrl;
    logic [2:0] k;
    logic [7:0] c;
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      c = {1'b0, k[2], k[1], k[1:0], k[0], 1'b0, k[2] ^ k[0]};
      u_host.wr(`USC_OFS_CTRL, c);
      settle();
      cmpBit(xcvrStandby, c[6]);
      cmpBit(suspendOut, c[6] & ~c[0]);
      cmpBit(lowSpeed, c[5]);
      cmpBit(lineForceOeN, c[4:3] == 2'b00);
      cmpBit(lineDpOut, c[4:3] == 2'b11);
      cmpBit(lineDmOut, c[4:3] == 2'b10);
      cmpBit(dmaReadDir, c[2]);
      cmpBit(usbEn, c[0]);
      rdChk(`USC_OFS_CTRL, c);
    end
  endtask : t_ctrl

  task automatic t_irq;
    logic [6:0] m;
    for (int i = 0; i < 7; i++) begin
      m = 7'h01 << i;
      u_host.clrStatus(8'h7F);
      u_host.wr(`USC_OFS_IEN, {1'b0, m});
      pulse(~m);
      settle();
      cmpBit(irq, 1'b0);
      rdChk(`USC_OFS_ISTAT, {1'b0, ~m});
      pulse(m);
      settle();
      cmpBit(irq, 1'b1);
      rdChk(`USC_OFS_IEN, {1'b0, m});
    end
    u_host.wr(`USC_OFS_IEN, 8'h00);
    settle();
    cmpBit(irq, 1'b0);
    rdChk(`USC_OFS_ISTAT, 8'h7F);
    u_host.clrStatus(8'h0F);
    rdChk(`USC_OFS_ISTAT, 8'h70);
    // Clear and new event on the same bit in one cycle
    u_host.setPtr(`USC_OFS_ISTAT);
    fork
      u_host.wrData(8'h70);
      pulse(7'h20);
    join
    rdChk(`USC_OFS_ISTAT, 8'h20);
    u_host.wr(`USC_OFS_IEN, 8'h20);
    settle();
    cmpBit(irq, 1'b1);
    u_host.clrStatus(8'h20);
    settle();
    cmpBit(irq, 1'b0);
  endtask : t_irq

  task automatic t_dma;
    int n0;
    n0 = nStart;
    u_host.wr(`USC_OFS_CTRL, 8'h06);
    u_host.dmaLen(16'h0123);
    settle();
    cmpVal(16'(nStart - n0), 16'h0001);
    cmpVal(dmaCount, 16'h0123);
    cmpBit(dmaActive, 1'b1);
    rdChk(`USC_OFS_IEN, 8'hA0);
    pulse(7'h10);
    settle();
    cmpBit(dmaActive, 1'b0);
    cmpBit(irq, 1'b0);
    rdChk(`USC_OFS_ISTAT, 8'h10);
    u_host.wr(`USC_OFS_CTRL, 8'h00);
    u_host.dmaLen(16'h0045);
    settle();
    cmpVal(16'(nStart - n0), 16'h0001);
    cmpBit(dmaActive, 1'b0);
  endtask : t_dma

  task automatic t_token;
    int a0;
    int r0;
    a0 = nAccept;
    r0 = nReject;
    u_host.wr(`USC_OFS_ADDR, 8'h2A);
    u_host.wr(`USC_OFS_CTRL, 8'h01);
    rdChk(`USC_OFS_ADDR, 8'h2A);
    token(8'h2A);
    token(8'h2B);
    token(8'hAA);
    settle();
    cmpVal(16'(nAccept - a0), 16'h0001);
    cmpVal(16'(nReject - r0), 16'h0002);
    u_host.wr(`USC_OFS_CTRL, 8'h00);
    token(8'h2A);
    settle();
    cmpVal(16'(nAccept - a0), 16'h0001);
    cmpVal(16'(nReject - r0), 16'h0003);
  endtask : t_token

  // Read-only, plain and unmapped places
  task automatic t_places;
    u_host.wr(`USC_OFS_CBUF, 8'h55);
    rdChk(`USC_OFS_CBUF, 8'h0A);
    rdChk(`USC_OFS_FRML, 8'h46);
    rdChk(`USC_OFS_FRMH, 8'hB0);
    // Second set of engine inputs so the read path is seen to follow them
    curBuf   <= 4'h3;
    frameNum <= 11'h2C1;
    rdChk(`USC_OFS_CBUF, 8'h03);
    rdChk(`USC_OFS_FRML, 8'h82);
    rdChk(`USC_OFS_FRMH, 8'h50);
    u_host.wr(`USC_OFS_ROLE, 8'hC0);
    rdChk(`USC_OFS_ROLE, 8'hC0);
    cmpVal({8'h00, rolePolarity}, 16'h00C0);
    u_host.wr(8'h20, 8'h77);
    rdChk(8'h20, 8'h00);
  endtask : t_places

  // Clock enable low: events and host writes are lost, state holds
  task automatic t_freeze;
    u_host.clrStatus(8'h7F);
    u_host.wr(`USC_OFS_IEN, 8'h01);
    @(posedge clk);
    ce <= 1'b0;
    pulse(7'h01);
    u_host.wr(`USC_OFS_CTRL, 8'h40);
    @(posedge clk);
    ce <= 1'b1;
    settle();
    cmpBit(irq, 1'b0);
    cmpBit(xcvrStandby, 1'b0);
    rdChk(`USC_OFS_ISTAT, 8'h00);
    rdChk(`USC_OFS_CTRL, 8'h00);
    u_host.wr(`USC_OFS_CTRL, 8'h40);
    settle();
    cmpBit(xcvrStandby, 1'b1);
  endtask : t_freeze

  // Second reset in mid-run with a forced J state and an address held
  task automatic t_rereset;
    u_host.wr(`USC_OFS_CTRL, 8'h18);
    u_host.wr(`USC_OFS_ADDR, 8'h5C);
    @(posedge clk);
    rstN <= 1'b0;
    repeat (2) @(posedge clk);
    rstN <= 1'b1;
    #1;
    cmpBit(lineForceOeN, 1'b1);
    rdChk(`USC_OFS_ADDR, 8'h00);
  endtask : t_rereset

  // Main sequence
  initial begin
    rstN           = 1'b0;
    ce             = 1'b1;
    evtIn          = '0;
    tokenIn        = '0;
    curBuf         = 4'hA;
    frameNum       = 11'h5A3;
    nMismatch      = 0;
    samplesChecked = 0;
    cycles         = 0;
    nAccept        = 0;
    nReject        = 0;
    nStart         = 0;
    repeat (6) @(posedge clk);
    rstN <= 1'b1;
    t_reset();
    t_ctrl();
    t_irq();
    t_dma();
    t_token();
    t_places();
    t_freeze();
    t_rereset();
    stop_test();
  end
endmodule : tb_top
